/* rtl/ldss_regs.svh */
// timing counts and mode constants for the linear detector scan sequencer
// assumes a 50 MHz mclk; counts are in detector clocks, except two in ns and LDSS_RST_HIGH_MIN_CYC in mclk cycles
`ifndef LDSS_REGS_SVH
`define LDSS_REGS_SVH
`define LDSS_FIRST_PIX_EDGE 16'h0017
`define LDSS_SAMPLE_EDGE 16'h0018
`define LDSS_PIX_PERIOD 16'h0004
`define LDSS_INTEG_START_EDGE 16'h0002
`define LDSS_INTEG_END_EDGE 16'h0007
`define LDSS_RST_LOW_MIN 16'h000C
`define LDSS_LINE_OVERHEAD 16'h0022
`define LDSS_RST_HIGH_MIN_NS 32'h00004E20
`define LDSS_CLK_PERIOD_NS 32'h00000014
`define LDSS_RST_HIGH_MIN_CYC ((`LDSS_RST_HIGH_MIN_NS + `LDSS_CLK_PERIOD_NS - 32'h1) / `LDSS_CLK_PERIOD_NS)
`define LDSS_N_COARSE 16'h0080
`endif

/* rtl/ldss_pkg.sv */
// state types for the two ends of the scan sequencer link, one type per end
// assumes ldss_regs.svh supplies the timing counts
package ldss_pkg;
   typedef enum logic [3:0]
   {
      LDSS_IDLE = 4'b0001,
      LDSS_WAIT = 4'b0010,
      LDSS_SCAN = 4'b0100,
      LDSS_DONE = 4'b1000
   } ldss_state_t;
   typedef enum logic [3:0]
   {
      LDSS_C_IDLE = 4'b0001,
      LDSS_C_HIGH = 4'b0010,
      LDSS_C_LOW = 4'b0100,
      LDSS_C_HOLD = 4'b1000
   } ldss_ctl_state_t;
endpackage

/* rtl/ldss_if.sv */
// link between the detector sequencer and its timing controller
// the controller owns the detector clock phase via det_clk_fall
interface ldss_if;
   logic det_clk_fall;
   logic reset_n;
   logic trig;
   logic end_of_scan_out_n;
   logic video_valid;
   logic [15:0] pixel_index;
   modport device
   (
      input det_clk_fall,
      input reset_n,
      output trig,
      output end_of_scan_out_n,
      output video_valid,
      output pixel_index
   );
   modport ctrl
   (
      output det_clk_fall,
      output reset_n,
      input trig,
      input end_of_scan_out_n,
      input video_valid,
      input pixel_index
   );
endinterface

/* rtl/ldss_device.sv */
// detector end: integration window and serial pixel sequencing
// assumes det_clk_fall is a one-cycle enable marking each detector clock falling edge
// Function
// - first pixel appears before 23rd falling edge
// - controller samples first pixel at 24th edge
// - one pixel every four clocks after first
// - controller avoids reset rise during readout
// - reset period at least 34 plus 4N
// - end-of-scan low during last pixel
// - reset low twelve cycles, multiple of four
// - reset high at least 20 us
// - reset rise starts integration and readout
// - integrate from edge 2 to edge 7
// - reset sampled on falling clock edges
// - trigger pulse marks valid pixel
// - gain select chooses sensitivity
// - pitch select chooses fine or coarse
// - parallel readout straps all as master
// - serial chain feeds slave from previous end-of-scan
// - master ignores chain-start input
// - chain shares clock, reset and video
// - pixel rate is quarter clock
`include "ldss_regs.svh"
module ldss_device
(
   input wire logic mclk,
   input wire logic sys_rst,
   ldss_if.device lnk,
   input wire logic master_slave_select,
   input wire logic chain_start_input,
   input wire logic gain_select,
   input wire logic pitch_select,
   output logic integrating,
   output logic high_sensitivity,
   output logic fine_pitch
);
   ldss_pkg::ldss_state_t state_q;
   logic rst_lvl_q;
   logic [15:0] edge_cnt_q;
   logic [15:0] pix_q;
   logic [1:0] phase_q;
   logic [15:0] pix_total;
   logic rise;
   logic fall;
   logic chain_q;
   logic chain_pulse;
   logic last_pix;

   // reset only seen on falling edges, so setup/hold lives at the controller
   assign rise = lnk.det_clk_fall && lnk.reset_n && !rst_lvl_q;
   assign fall = lnk.det_clk_fall && !lnk.reset_n && rst_lvl_q;
   assign pix_total = pitch_select ? 16'(`LDSS_N_COARSE << 1) : `LDSS_N_COARSE;
   // trailing edge of the upstream end-of-scan, so two videos never overlap
   assign chain_pulse = lnk.det_clk_fall && chain_start_input && !chain_q;
   assign last_pix = (pix_q == pix_total - 16'h0001);

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rst_lvl_q <= 1'b0;
         chain_q <= 1'b1;
      end
      else if (lnk.det_clk_fall)
      begin
         rst_lvl_q <= lnk.reset_n;
         chain_q <= chain_start_input;
      end
   end

   // edge counter since last reset transition
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         edge_cnt_q <= 16'h0000;
      else if (rise || fall)
         edge_cnt_q <= 16'h0001;
      else if (lnk.det_clk_fall && edge_cnt_q != 16'hFFFF)
         edge_cnt_q <= edge_cnt_q + 16'h0001;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         integrating <= 1'b0;
      else if (lnk.det_clk_fall && rst_lvl_q && edge_cnt_q == `LDSS_INTEG_START_EDGE - 16'h0001)
         integrating <= 1'b1;
      else if (lnk.det_clk_fall && !rst_lvl_q && edge_cnt_q == `LDSS_INTEG_END_EDGE - 16'h0001)
         integrating <= 1'b0;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         high_sensitivity <= 1'b0;
         fine_pitch <= 1'b0;
      end
      else
      begin
         high_sensitivity <= gain_select;
         fine_pitch <= pitch_select;
      end
   end

   // sequencer: wait for the 22nd edge (master) or chain start (slave)
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ldss_pkg::LDSS_IDLE;
         pix_q <= 16'h0000;
         phase_q <= 2'b00;
      end
      else
      begin
         case (state_q)
            ldss_pkg::LDSS_IDLE:
            begin
               if (rise)
                  state_q <= ldss_pkg::LDSS_WAIT;
            end
            ldss_pkg::LDSS_WAIT:
            begin
               if (master_slave_select)
               begin
                  // chain_start_input is ignored here
                  if (lnk.det_clk_fall && edge_cnt_q == `LDSS_FIRST_PIX_EDGE - 16'h0002)
                  begin
                     state_q <= ldss_pkg::LDSS_SCAN;
                     pix_q <= 16'h0000;
                     phase_q <= 2'b00;
                  end
               end
               else if (chain_pulse)
               begin
                  state_q <= ldss_pkg::LDSS_SCAN;
                  pix_q <= 16'h0000;
                  phase_q <= 2'b00;
               end
            end
            ldss_pkg::LDSS_SCAN:
            begin
               if (lnk.det_clk_fall)
               begin
                  phase_q <= phase_q + 2'b01;
                  if (phase_q == 2'b11)
                  begin
                     if (last_pix)
                        state_q <= ldss_pkg::LDSS_DONE;
                     else
                        pix_q <= pix_q + 16'h0001;
                  end
               end
            end
            ldss_pkg::LDSS_DONE:
            begin
               state_q <= ldss_pkg::LDSS_IDLE;
            end
            default:
            begin
               state_q <= ldss_pkg::LDSS_IDLE;
            end
         endcase
      end
   end

   // outputs registered; slave idles its video while others read out
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lnk.trig <= 1'b0;
         lnk.end_of_scan_out_n <= 1'b1;
         lnk.video_valid <= 1'b0;
         lnk.pixel_index <= 16'h0000;
      end
      else
      begin
         lnk.video_valid <= (state_q == ldss_pkg::LDSS_SCAN);
         lnk.pixel_index <= pix_q;
         // one mclk wide: only on the detector clock edge inside the slot
         lnk.trig <= (state_q == ldss_pkg::LDSS_SCAN) && (phase_q == 2'b01)
            && lnk.det_clk_fall;
         lnk.end_of_scan_out_n <= !((state_q == ldss_pkg::LDSS_SCAN) && last_pix);
      end
   end
endmodule

/* rtl/ldss_ctrl.sv */
// controller end: makes detector clock edges and the reset pulse
// detector clock = mclk/4, det_clk_fall marks its falling edge
`include "ldss_regs.svh"
module ldss_ctrl
(
   input wire logic mclk,
   input wire logic sys_rst,
   ldss_if.ctrl lnk,
   input wire logic start,
   input wire logic [15:0] integ_fall_edges,
   input wire logic [15:0] pix_total,
   output logic busy,
   output logic sample_stb,
   output logic [15:0] sample_index,
   output logic line_done
);
   ldss_pkg::ldss_ctl_state_t state_q;
   logic [1:0] div_q;
   logic [31:0] cnt_q;
   logic [31:0] high_min;
   logic tick;

   assign tick = (div_q == 2'b11);
   assign lnk.det_clk_fall = tick;
   assign busy = (state_q != ldss_pkg::LDSS_C_IDLE);
   // high at least 20 us and a full line; reset edges only change between falls
   assign high_min = (`LDSS_RST_HIGH_MIN_CYC / 32'h4 > {16'h0000, `LDSS_LINE_OVERHEAD} + {14'h0, pix_total, 2'b00}) ?
      `LDSS_RST_HIGH_MIN_CYC / 32'h4 : {16'h0000, `LDSS_LINE_OVERHEAD} + {14'h0, pix_total, 2'b00};

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         div_q <= 2'b00;
      else
         div_q <= div_q + 2'b01;
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ldss_pkg::LDSS_C_IDLE;
         cnt_q <= 32'h0;
         lnk.reset_n <= 1'b0;
      end
      else if (tick)
      begin
         cnt_q <= cnt_q + 32'h1;
         case (state_q)
            ldss_pkg::LDSS_C_IDLE:
            begin
               // low spell stays a whole number of four detector clocks
               if (start && cnt_q[1:0] == 2'b11)
               begin
                  lnk.reset_n <= 1'b1;
                  cnt_q <= 32'h0;
                  state_q <= ldss_pkg::LDSS_C_HIGH;
               end
            end
            ldss_pkg::LDSS_C_HIGH:
            begin
               // no fall before the last pixel is out
               if (cnt_q + 32'h1 >= high_min && cnt_q + 32'h1 >= {16'h0, integ_fall_edges})
               begin
                  lnk.reset_n <= 1'b0;
                  cnt_q <= 32'h0;
                  state_q <= ldss_pkg::LDSS_C_LOW;
               end
            end
            ldss_pkg::LDSS_C_LOW:
            begin
               // 12 detector clocks is a multiple of four
               if (cnt_q + 32'h1 >= {16'h0, `LDSS_RST_LOW_MIN})
               begin
                  state_q <= ldss_pkg::LDSS_C_HOLD;
               end
            end
            ldss_pkg::LDSS_C_HOLD:
            begin
               state_q <= ldss_pkg::LDSS_C_IDLE;
            end
            default:
            begin
               state_q <= ldss_pkg::LDSS_C_IDLE;
            end
         endcase
      end
   end

   // sample on trigger; daisy chain and mode straps are board wiring
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sample_stb <= 1'b0;
         sample_index <= 16'h0000;
         line_done <= 1'b0;
      end
      else
      begin
         sample_stb <= lnk.trig && lnk.video_valid;
         line_done <= lnk.trig && !lnk.end_of_scan_out_n;
         if (lnk.trig)
            sample_index <= lnk.pixel_index;
      end
   end
endmodule

/* tb/ldss_assertions.sv */
// link checks between the scan controller and the master detector
// assumes the bench wires the link signals in by name
module ldss_assertions
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic det_clk_fall,
   input wire logic reset_n,
   input wire logic trig,
   input wire logic end_of_scan_out_n,
   input wire logic video_valid,
   input wire logic [15:0] pixel_index
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] lo_q;
   logic [15:0] hi_q;
   logic arm_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // arm skips the low spell left over from system reset
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lo_q <= 16'h0000;
         hi_q <= 16'h0000;
         arm_q <= 1'b0;
      end
      else
      begin
         lo_q <= reset_n ? 16'h0000 : lo_q + 16'h0001;
         hi_q <= reset_n ? hi_q + 16'h0001 : 16'h0000;
         arm_q <= arm_q | (!reset_n & (hi_q != 16'h0000));
      end
   end
   trig_pulse_a: assert property (trig |=> !trig)
      else $error("trig wider than one cycle");
   trig_scan_a: assert property (trig |-> video_valid)
      else $error("trig outside a scan");
   pix_period_a: assert property (trig && end_of_scan_out_n |-> ##16
      (trig && pixel_index == $past(pixel_index, 16) + 16'h0001))
      else $error("pixel slot not four detector clocks");
   first_pix_a: assert property ($rose(reset_n) |-> ##[80:96] $rose(video_valid))
      else $error("first pixel late or early");
   pix_zero_a: assert property ($rose(video_valid) |-> pixel_index == 16'h0000)
      else $error("scan not starting at pixel zero");
   rise_idle_a: assert property ($rose(reset_n) |-> !video_valid)
      else $error("reset rise during readout");
   eos_width_a: assert property ($fell(end_of_scan_out_n) |->
      (!end_of_scan_out_n)[*8] ##[8:9] end_of_scan_out_n)
      else $error("end of scan width wrong");
   eos_end_a: assert property ($rose(end_of_scan_out_n) |-> ##[0:4] !video_valid)
      else $error("scan continues past end of scan");
   edge_align_a: assert property ($changed(reset_n) |-> $past(det_clk_fall))
      else $error("reset changed off a detector clock edge");
   low_width_a: assert property ($rose(reset_n) && arm_q |->
      lo_q >= 16'h0030 && lo_q[3:0] == 4'h0)
      else $error("reset low width wrong");
   high_width_a: assert property ($fell(reset_n) |-> hi_q >= 16'h0888)
      else $error("reset period too short");
   cover property ($rose(video_valid));
   cover property ($fell(end_of_scan_out_n));
   cover property ($rose(reset_n) && arm_q);
endmodule

/* tb/tb_linear_detector_scan_sequencer.sv */
// bench: controller, master detector and chained slave detector
// assumes rtl package, interface and ldss_regs.svh compiled first
module tb_linear_detector_scan_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0;
   logic [15:0] integ = 16'h0000;
   logic [15:0] npix = 16'h0080;
   logic gain = 1'b0;
   logic pitch = 1'b0;
   logic ext = 1'b1;
   logic rst_seen = 1'b0;
   logic busy, sstb, done, in_a, in_b, hs_a, hs_b, fp_a, fp_b;
   logic [15:0] sidx;
   int failures = 0;
   int total_checks = 0;
   int l;
   logic [15:0] exp_q[$];
   logic [15:0] exp_b[$];
   ldss_if lnk();
   ldss_if lnk_b();
   assign lnk_b.det_clk_fall = lnk.det_clk_fall;
   assign lnk_b.reset_n = lnk.reset_n;
   ldss_ctrl ldss_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk), .start(start),
      .integ_fall_edges(integ),
      .pix_total({npix[14:0], 1'b0}), // the line spans both chained detectors
      .busy(busy), .sample_stb(sstb),
      .sample_index(sidx), .line_done(done));
   ldss_device ldss_device_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk),
      .master_slave_select(1'b1), .chain_start_input(ext), .gain_select(gain),
      .pitch_select(pitch), .integrating(in_a), .high_sensitivity(hs_a), .fine_pitch(fp_a));
   ldss_device ldss_device_inst_b (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk_b),
      .master_slave_select(1'b0), .chain_start_input(lnk.end_of_scan_out_n),
      .gain_select(gain), .pitch_select(pitch), .integrating(in_b),
      .high_sensitivity(hs_b), .fine_pitch(fp_b));
   ldss_assertions ldss_assertions_inst (.mclk(mclk), .sys_rst(sys_rst),
      .det_clk_fall(lnk.det_clk_fall), .reset_n(lnk.reset_n), .trig(lnk.trig),
      .end_of_scan_out_n(lnk.end_of_scan_out_n), .video_valid(lnk.video_valid),
      .pixel_index(lnk.pixel_index));
   initial
   begin
      forever #10 mclk = ~mclk;
   end
   task automatic chk(string what, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wait_hi(int w, int lim, logic v = 1'b1);
      int i;
      for (i = 0; i < lim && (w ? done : busy) !== v; i++)
         @(negedge mclk);
      if ((w ? done : busy) !== v)
      begin
         failures++;
         $display("ERROR handshake expected %b seen %b", v, (w ? done : busy));
         conclude();
      end
   endtask
   task automatic run_line(logic f);
      int i;
      // the previous reset period must be over before a new line is asked for
      wait_hi(0, 8000, 1'b0);
      pitch = f;
      gain = 1'($urandom);
      npix = f ? 16'h0100 : 16'h0080;
      integ = 16'($urandom_range(1200));
      for (i = 0; i < 32'(npix); i++)
      begin
         exp_q.push_back(16'(i));
         exp_b.push_back(16'(i));
      end
      start = 1'b1;
      wait_hi(0, 200);
      start = 1'b0;
      wait_hi(1, 8000);
      // slave readout trails the master line, so wait for its pixels
      for (i = 0; i < 6000 && exp_b.size() != 0; i++)
         @(negedge mclk);
      chk("slave_left", 16'h0000, 16'(exp_b.size()));
      if (exp_b.size() != 0)
         conclude();
   endtask
   // master must ignore this wandering chain-start input
   always @(negedge mclk)
      ext <= 1'($urandom);
   always @(negedge mclk)
   begin
      if (sstb === 1'b1)
         chk("sample_index", exp_q.size() ? exp_q.pop_front() : 16'hFFFF, sidx);
      if (lnk_b.trig === 1'b1)
         chk("slave_index", exp_b.size() ? exp_b.pop_front() : 16'hFFFF, lnk_b.pixel_index);
      if (lnk.trig === 1'b1 && lnk.end_of_scan_out_n === 1'b0)
         chk("eos_index", npix - 16'h0001, lnk.pixel_index);
      if (lnk_b.trig === 1'b1 && lnk_b.end_of_scan_out_n === 1'b0)
         chk("slave_eos", npix - 16'h0001, lnk_b.pixel_index);
      if (lnk.reset_n === 1'b1 && rst_seen === 1'b0)
         chk("integ_end", 16'h0000, {15'h0000, in_a});
      rst_seen <= lnk.reset_n;
      if (lnk.video_valid === 1'b1)
         chk("slave_idle", 16'h0000, {15'h0000, lnk_b.video_valid});
      if (done === 1'b1)
      begin
         chk("gain", {15'h0000, gain}, {15'h0000, hs_a});
         chk("pitch", {15'h0000, pitch}, {15'h0000, fp_b});
         chk("gain_b", {15'h0000, gain}, {15'h0000, hs_b});
         chk("pitch_a", {15'h0000, pitch}, {15'h0000, fp_a});
         chk("integ_a", 16'h0001, {15'h0000, in_a});
         chk("integ_b", 16'h0001, {15'h0000, in_b});
      end
   end
   initial
   begin
      void'($urandom(32'h4DCB));
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      for (l = 0; l < 4; l++)
         run_line(l[0]);
      chk("leftover", 16'h0000, 16'(exp_q.size()));
      conclude();
   end
endmodule
